// File: rtl/flash_host.sv
// host controller for an asynchronous parallel nor flash, avalon-mm slave to software
// assumes one 200 MHz clock; all flash pins are outside this clock's domain
// Contract
// R1: device refuses program and erase in protected sectors until unprotected.
// R2: high voltage on reset pin makes protected sectors temporarily writable.
// R3: removing high voltage re-protects sectors; stored protection flags unchanged.
// R4: new devices ship with every sector unprotected.
// R5: below supply lockout the device ignores writes and stays reset.
// R6: write cycle only with chip select and write low, output gate high.
// R7: strobes low at power-up give no command; device starts in read-array.
// R8: wrong address, data or order returns device to read-array.
// R9: address latched on later falling strobe, data on earlier rising strobe.
// R10: read-array after power-up and after embedded algorithm completion.
// R11: erase-suspend reads give status inside suspended sectors, array elsewhere.
// R12: host writes reset command after time-limit flag or while in autoselect.
// R13: reset command returns to read-array whatever the address bits.
// R14: reset aborts a partial sequence; ignored once embedded operation runs.
// R15: two unlocks then autoselect command; then any reads, any address.
// R16: autoselect offset 00h gives maker code, 01h word/02h byte device code.
// R17: autoselect offset 02h word/04h byte gives sector protection 01h/00h.
// R18: host issues reset command to leave autoselect; device stays until then.
// R19: program is two unlocks, set-up command, then address and data.
// R20: after programming device returns to read-array; progress on status bits.
// R21: command writes ignored while programming; hardware reset aborts at once.
// R22: programming only clears bits; raising a zero may set time-limit flag.
// R23: reset during program or erase keeps ready/busy low until done.
// R24: unlock addresses, data and command codes are design parameters.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module flash_host #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16,
  parameter logic [17:0] UNLOCK1_ADDR = `FH_UNLOCK1_ADDR,
  parameter logic [15:0] UNLOCK1_DATA = `FH_UNLOCK1_DATA,
  parameter logic [17:0] UNLOCK2_ADDR = `FH_UNLOCK2_ADDR,
  parameter logic [15:0] UNLOCK2_DATA = `FH_UNLOCK2_DATA,
  parameter logic [15:0] PROG_CMD = `FH_PROG_CMD,
  parameter logic [15:0] AUTOSEL_CMD = `FH_AUTOSEL_CMD,
  parameter logic [15:0] RESET_CMD = `FH_RESET_CMD,
  parameter logic [15:0] POLL_LIMIT = `FH_POLL_LIMIT
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_byte_n_out,
  output logic flash_reset_n_out,
  input wire logic ready_busy_in
);
  localparam logic [15:0] RP_C = 16'(`FH_CYC_MIN(`FH_T_RP_NS));
  localparam logic [15:0] RH_C = 16'(`FH_CYC_MIN(`FH_T_RH_NS));

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_WAIT, S_POLL, S_POLL_WAIT, S_HWRST, S_HWREC} st_t;

  st_t st_q, st_d;
  flash_host_pkg::op_t op_q, op_d;
  logic [2:0] idx_q, idx_d, prev_idx_q, prev_idx_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] data_q, data_d, rdata_q, rdata_d;
  logic byte_q, byte_d, autosel_q, autosel_d, tlimit_q, tlimit_d, err_q, err_d;
  logic tl_seen_q, tl_seen_d, rst_n_q, rst_n_d, byte_n_q, byte_n_d;
  logic [15:0] cnt_q, cnt_d;
  logic wait_q, wait_d;
  logic [31:0] rd_q, rd_d;
  logic cyc_start_q, cyc_start_d, cyc_write_q, cyc_write_d;
  logic [ADDR_W-1:0] cyc_addr_q, cyc_addr_d;
  logic [DATA_W-1:0] cyc_wdata_q, cyc_wdata_d;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic rb_s1_q, rb_s2_q;
  logic accept, wr_take, tl_fail;
  logic [ADDR_W+DATA_W:0] step;

  // one step of a command sequence: {is_write, address, data}
  function automatic logic [ADDR_W+DATA_W:0] step_of(input flash_host_pkg::op_t op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] ua, input logic [DATA_W-1:0] ud,
      input logic bm);
    logic [ADDR_W-1:0] a1;
    logic [ADDR_W-1:0] a2;
    a1 = bm ? ADDR_W'({UNLOCK1_ADDR, 1'b0}) : ADDR_W'(UNLOCK1_ADDR);
    a2 = bm ? ADDR_W'({UNLOCK2_ADDR, 1'b0}) : ADDR_W'(UNLOCK2_ADDR);
    step_of = {1'b1, ua, DATA_W'(RESET_CMD)};       // reset needs no address [R12]
    if (op == flash_host_pkg::OP_READ) begin
      step_of = {1'b0, ua, ud};
    end else if (op == flash_host_pkg::OP_PROGRAM || op == flash_host_pkg::OP_AUTOSEL) begin
      case (idx)
        3'h1: step_of = {1'b1, a1, DATA_W'(UNLOCK1_DATA)};   // [R15] [R19]
        3'h2: step_of = {1'b1, a2, DATA_W'(UNLOCK2_DATA)};   // [R15] [R19]
        3'h3: step_of = {1'b1, a1, (op == flash_host_pkg::OP_PROGRAM) ?
          DATA_W'(PROG_CMD) : DATA_W'(AUTOSEL_CMD)};        // [R15] [R19]
        3'h4: step_of = {1'b1, ua, ud};                      // [R19]
        default: step_of = {1'b1, ua, DATA_W'(RESET_CMD)};
      endcase
    end
  endfunction

  // avalon register read view
  function automatic logic [31:0] reg_read(input logic [2:0] a);
    reg_read = 32'h0000_0000;
    case (a)
      `FH_REG_ADDR: reg_read = 32'(addr_q);
      `FH_REG_DATA: reg_read = 32'(data_q);
      `FH_REG_CTRL: reg_read = 32'({byte_q, 1'b0, op_q});
      `FH_REG_STATUS: reg_read = {16'(rdata_q), 11'h000, err_q, autosel_q, tl_seen_q,
        rb_s2_q, (st_q != S_IDLE)};
      `FH_REG_RDATA: reg_read = 32'(rdata_q);
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  assign step = step_of(op_q, idx_q, addr_q, data_q, byte_q);
  // a start while busy is held off by waitrequest, never dropped
  assign accept = (avs_read_in || avs_write_in) && wait_q &&
    !(avs_write_in && avs_address_in == `FH_REG_CTRL && st_q != S_IDLE);
  assign wr_take = avs_write_in && !wait_q;

  // sequencer: command steps, polling, hardware reset
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    idx_d = idx_q;
    prev_idx_d = prev_idx_q;
    addr_d = addr_q;
    data_d = data_q;
    rdata_d = rdata_q;
    byte_d = byte_q;
    autosel_d = autosel_q;
    tlimit_d = tlimit_q;
    err_d = err_q;
    tl_seen_d = tl_seen_q;
    rst_n_d = rst_n_q;
    cnt_d = cnt_q;
    cyc_start_d = 1'b0;
    cyc_write_d = cyc_write_q;
    cyc_addr_d = cyc_addr_q;
    cyc_wdata_d = cyc_wdata_q;
    tl_fail = 1'b0;
    wait_d = !accept;
    rd_d = accept ? reg_read(avs_address_in) : rd_q;
    if (wr_take && avs_address_in == `FH_REG_ADDR) addr_d = ADDR_W'(avs_writedata_in);
    if (wr_take && avs_address_in == `FH_REG_DATA) data_d = DATA_W'(avs_writedata_in);
    case (st_q)
      S_IDLE: if (wr_take && avs_address_in == `FH_REG_CTRL) begin
        op_d = flash_host_pkg::op_t'(avs_writedata_in[`FH_CTRL_OP_MSB:`FH_CTRL_OP_LSB]);
        byte_d = avs_writedata_in[`FH_CTRL_BYTE_BIT];
        err_d = 1'b0;
        tlimit_d = 1'b0;
        cnt_d = 16'h0000;
        // leave autoselect with a reset command before programming [R12] [R18]
        idx_d = (op_d == flash_host_pkg::OP_AUTOSEL ||
          (op_d == flash_host_pkg::OP_PROGRAM && !autosel_q)) ? 3'h1 : 3'h0;
        prev_idx_d = 3'h7;
        if (op_d == flash_host_pkg::OP_HWRESET) begin
          rst_n_d = 1'b0;
          cnt_d = RP_C;
          st_d = S_HWRST;
        end else if (op_d != flash_host_pkg::OP_NONE) begin
          st_d = S_STEP;
        end
      end
      S_STEP: begin
        cyc_start_d = 1'b1;
        cyc_write_d = step[ADDR_W+DATA_W];
        cyc_addr_d = step[ADDR_W+DATA_W-1:DATA_W];
        cyc_wdata_d = step[DATA_W-1:0];
        prev_idx_d = idx_q;
        st_d = S_WAIT;
      end
      S_WAIT: if (cyc_done) begin
        if (!cyc_write_q) rdata_d = cyc_rdata;
        if (cyc_write_q && cyc_wdata_q == DATA_W'(RESET_CMD)) autosel_d = 1'b0; // [R18]
        if (op_q == flash_host_pkg::OP_AUTOSEL && idx_q == 3'h3) autosel_d = 1'b1; // [R15]
        if (op_q == flash_host_pkg::OP_PROGRAM && idx_q == 3'h4) begin
          st_d = S_POLL;                                   // [R19]
        end else if (op_q == flash_host_pkg::OP_PROGRAM ||
            (op_q == flash_host_pkg::OP_AUTOSEL && idx_q != 3'h3)) begin
          idx_d = idx_q + 3'h1;
          st_d = S_STEP;
        end else begin
          st_d = S_IDLE;
        end
      end
      // data polling: the status bit matches the written data once done
      S_POLL: begin
        cyc_start_d = 1'b1;
        cyc_write_d = 1'b0;
        cyc_addr_d = addr_q;
        cnt_d = cnt_q + 16'h0001;
        st_d = S_POLL_WAIT;
      end
      S_POLL_WAIT: if (cyc_done) begin
        rdata_d = cyc_rdata;
        if (cyc_rdata[`FH_POLL_BIT] == data_q[`FH_POLL_BIT]) begin
          st_d = S_IDLE;
        end else if (tlimit_q || cnt_q == POLL_LIMIT) begin
          // time-limit flag confirmed or poll limit reached: recover the device with a reset command [R12]
          tl_fail = tlimit_q;
          err_d = 1'b1;
          op_d = flash_host_pkg::OP_RESET;
          idx_d = 3'h0;
          st_d = S_STEP;
        end else begin
          tlimit_d = cyc_rdata[`FH_TLIMIT_BIT];   // one more read confirms it
          tl_seen_d = tl_seen_q | cyc_rdata[`FH_TLIMIT_BIT];
          st_d = S_POLL;
        end
      end
      S_HWRST: begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001) begin
          rst_n_d = 1'b1;
          cnt_d = RH_C;
          st_d = S_HWREC;
        end
      end
      // wait for the recovery time and for the ready/busy pin to go high
      S_HWREC: begin
        autosel_d = 1'b0;
        cnt_d = (cnt_q == 16'h0000) ? cnt_q : cnt_q - 16'h0001;
        if (cnt_q == 16'h0000 && rb_s2_q) st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    byte_n_d = !byte_d;                // width pin is low for byte mode
  end

  // registers of the sequencer and the avalon slave
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= S_IDLE;
      op_q <= flash_host_pkg::OP_NONE;
      idx_q <= 3'h0;
      prev_idx_q <= 3'h7;
      addr_q <= '0;
      data_q <= '0;
      rdata_q <= '0;
      byte_q <= 1'b0;
      autosel_q <= 1'b0;
      tlimit_q <= 1'b0;
      err_q <= 1'b0;
      tl_seen_q <= 1'b0;
      rst_n_q <= 1'b1;
      byte_n_q <= 1'b1;
      cnt_q <= 16'h0000;
      wait_q <= 1'b1;
      rd_q <= 32'h0000_0000;
      cyc_start_q <= 1'b0;
      cyc_write_q <= 1'b0;
      cyc_addr_q <= '0;
      cyc_wdata_q <= '0;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      prev_idx_q <= prev_idx_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      byte_q <= byte_d;
      autosel_q <= autosel_d;
      tlimit_q <= tlimit_d;
      err_q <= err_d;
      tl_seen_q <= tl_seen_d;
      rst_n_q <= rst_n_d;
      byte_n_q <= byte_n_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
      rd_q <= rd_d;
      cyc_start_q <= cyc_start_d;
      cyc_write_q <= cyc_write_d;
      cyc_addr_q <= cyc_addr_d;
      cyc_wdata_q <= cyc_wdata_d;
      rb_s1_q <= ready_busy_in;
      rb_s2_q <= rb_s1_q;
    end
  end

  assign avs_readdata_out = rd_q;
  assign avs_waitrequest_out = wait_q;
  assign flash_byte_n_out = byte_n_q;
  assign flash_reset_n_out = rst_n_q;

  // pin timing lives in the cycle engine
  flash_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .start_in(cyc_start_q),
    .write_in(cyc_write_q),
    .addr_in(cyc_addr_q),
    .wdata_in(cyc_wdata_q),
    .dq_in(flash_dq_in),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .ce_n_out(flash_ce_n_out),
    .we_n_out(flash_we_n_out),
    .oe_n_out(flash_oe_n_out),
    .addr_out(flash_addr_out),
    .dq_out(flash_dq_out),
    .dq_oe_out(flash_dq_oe_out)
  );

  sequence s_prog_step;
    st_q == S_STEP && op_q == flash_host_pkg::OP_PROGRAM && idx_q > 3'h1;
  endsequence
  property p_prog_order;
    @(posedge mclk_in) disable iff (!rstn_in)
      s_prog_step |-> (prev_idx_q == idx_q - 3'h1) ##1 (cyc_start_q && cyc_write_q);
  endproperty
  a_prog_order: assert property (p_prog_order) else $error("program steps out of order"); // [R19]
  property p_auto_enter;
    @(posedge mclk_in) disable iff (!rstn_in)
      (cyc_done && st_q == S_WAIT && op_q == flash_host_pkg::OP_AUTOSEL && idx_q == 3'h3)
        |=> autosel_q && st_q == S_IDLE;
  endproperty
  a_auto_enter: assert property (p_auto_enter) else $error("autoselect mode not entered"); // [R15]
  property p_auto_exit;
    @(posedge mclk_in) disable iff (!rstn_in)
      (autosel_q && !(cyc_done && cyc_write_q && cyc_wdata_q == DATA_W'(RESET_CMD))
        && st_q != S_HWREC) |=> autosel_q;
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("autoselect left without reset"); // [R18]
  property p_tl_reset;
    @(posedge mclk_in) disable iff (!rstn_in)
      tl_fail |-> ##[1:3] (cyc_start_q && cyc_write_q && cyc_wdata_q == DATA_W'(RESET_CMD));
  endproperty
  a_tl_reset: assert property (p_tl_reset) else $error("no reset after time-limit flag"); // [R12]
endmodule // flash_host

// File: common/flash_host_consts.svh
// constants of the parallel nor flash host controller: offsets, fields, timing counts
// assumes the includer runs on a 200 MHz clock; all ns timings convert to cycle counts at that rate
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

`define FH_CLK_MHZ 200
// least time in ns -> whole cycles, rounded up, never below one
`define FH_CYC_MIN(ns) (((((ns) * `FH_CLK_MHZ) + 999) / 1000) < 1 ? 1 : \
  ((((ns) * `FH_CLK_MHZ) + 999) / 1000))

// pin timing, ns; synchroniser depth in cycles
`define FH_T_SETUP_NS 10
`define FH_T_WP_NS 40
`define FH_T_WPH_NS 20
`define FH_T_ACC_NS 70
`define FH_T_GAP_NS 20
`define FH_T_RP_NS 500
`define FH_T_RH_NS 50
`define FH_SYNC_CYC 2

// avalon register word indices
`define FH_REG_ADDR 3'h0
`define FH_REG_DATA 3'h1
`define FH_REG_CTRL 3'h2
`define FH_REG_STATUS 3'h3
`define FH_REG_RDATA 3'h4

// control fields
`define FH_CTRL_OP_LSB 0
`define FH_CTRL_OP_MSB 2
`define FH_CTRL_BYTE_BIT 4

// status fields
`define FH_ST_BUSY 0
`define FH_ST_READY 1
`define FH_ST_TLIMIT 2
`define FH_ST_AUTOSEL 3
`define FH_ST_ERROR 4

// flash status bits
`define FH_POLL_BIT 7
`define FH_TLIMIT_BIT 5

// command defaults (word-mode addresses)
`define FH_UNLOCK1_ADDR 18'h00555
`define FH_UNLOCK1_DATA 16'h00aa
`define FH_UNLOCK2_ADDR 18'h002aa
`define FH_UNLOCK2_DATA 16'h0055
`define FH_PROG_CMD 16'h00a0
`define FH_AUTOSEL_CMD 16'h0090
`define FH_RESET_CMD 16'h00f0
`define FH_POLL_LIMIT 16'hffff

`endif

// File: common/flash_host_pkg.sv
// types shared by the flash host controller
// assumes flash_host_consts.svh for all numeric values
package flash_host_pkg;
  // operation codes written to the control register, in this order from zero
  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_PROGRAM, OP_AUTOSEL, OP_RESET, OP_HWRESET
  } op_t;
endpackage

// File: rtl/flash_bus_cycle.sv
// one asynchronous bus cycle (read or write) on the flash pins
// assumes start_in is a one-cycle pulse given only while idle; dq_in is asynchronous
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module flash_bus_cycle #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out
);
  localparam logic [7:0] SETUP_C = 8'(`FH_CYC_MIN(`FH_T_SETUP_NS));
  localparam logic [7:0] WP_C = 8'(`FH_CYC_MIN(`FH_T_WP_NS));
  localparam logic [7:0] WPH_C = 8'(`FH_CYC_MIN(`FH_T_WPH_NS));
  localparam logic [7:0] RD_C = 8'(`FH_CYC_MIN(`FH_T_ACC_NS) + `FH_SYNC_CYC + 1);
  localparam logic [7:0] GAP_C = 8'(`FH_CYC_MIN(`FH_T_GAP_NS));

  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ, C_GAP} cyc_state_t;

  cyc_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic done_d, ce_n_d, we_n_d, oe_n_d, dq_oe_d;
  logic [DATA_W-1:0] rdata_d, dq_d;
  logic [ADDR_W-1:0] addr_d;

  // write strobe only falls inside an asserted chip select with output gate high
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q - 8'h01;
    done_d = 1'b0;
    ce_n_d = ce_n_out;
    we_n_d = 1'b1;
    oe_n_d = oe_n_out;
    dq_oe_d = dq_oe_out;
    rdata_d = rdata_out;
    dq_d = dq_out;
    addr_d = addr_out;
    case (st_q)
      C_IDLE: begin
        cnt_d = cnt_q;
        if (start_in) begin
          addr_d = addr_in;
          ce_n_d = 1'b0;
          dq_d = wdata_in;
          oe_n_d = write_in;          // [R6]
          dq_oe_d = write_in;
          st_d = write_in ? C_SETUP : C_READ;
          cnt_d = write_in ? SETUP_C : RD_C;
        end
      end
      C_SETUP: if (cnt_q == 8'h01) begin
        we_n_d = 1'b0;                // [R6]
        st_d = C_PULSE;
        cnt_d = WP_C;
      end
      C_PULSE: begin
        we_n_d = (cnt_q == 8'h01);
        if (cnt_q == 8'h01) begin
          st_d = C_HOLD;
          cnt_d = WPH_C;
        end
      end
      C_HOLD: if (cnt_q == 8'h01) begin
        ce_n_d = 1'b1;
        st_d = C_GAP;
        cnt_d = GAP_C;
      end
      C_READ: if (cnt_q == 8'h01) begin
        rdata_d = dq_s2_q;            // data settled through the synchroniser
        ce_n_d = 1'b1;
        oe_n_d = 1'b1;
        st_d = C_GAP;
        cnt_d = GAP_C;
      end
      C_GAP: begin
        dq_oe_d = 1'b0;
        oe_n_d = 1'b1;
        if (cnt_q == 8'h01) begin
          done_d = 1'b1;
          st_d = C_IDLE;
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  // pins idle deselected; dq inputs pass two flops before use
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= C_IDLE;
      cnt_q <= 8'h00;
      done_out <= 1'b0;
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      dq_oe_out <= 1'b0;
      rdata_out <= '0;
      dq_out <= '0;
      addr_out <= '0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_out <= done_d;
      ce_n_out <= ce_n_d;
      we_n_out <= we_n_d;
      oe_n_out <= oe_n_d;
      dq_oe_out <= dq_oe_d;
      rdata_out <= rdata_d;
      dq_out <= dq_d;
      addr_out <= addr_d;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  property p_write_gate;
    @(posedge mclk_in) disable iff (!rstn_in)
      !we_n_out |-> (!ce_n_out && oe_n_out);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write strobe outside valid gate"); // [R6]

  property p_no_contention;
    @(posedge mclk_in) disable iff (!rstn_in)
      (!oe_n_out |-> !dq_oe_out) and ($fell(we_n_out) |-> dq_oe_out [*2]);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("dq drive clashes with gate"); // [R6]
endmodule // flash_bus_cycle

// File: testbench/flash_dev_model.sv
// behavioural parallel nor flash seen from its pins, the far side of the host controller
// assumes one host drives the strobes; small array of 256 cells, word-mode map by default
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005a, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h00c3, // arbitrary value
  parameter int PROG_NS = 300,
  parameter int RDY_NS = 200
) (
  input wire logic [17:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic byte_n_in,
  input wire logic reset_n_in,
  output logic [15:0] dq_out,
  output logic ready_busy_out
);
  // st: 0 array, 1-2 unlocked, 3 program set-up, 4 autoselect, 5 programming, 6 failed
  int st = 0;
  logic [15:0] mem [0:255];
  logic [7:0] prot = 8'h00;
  logic [17:0] la = 18'h0;
  logic [17:0] pa = 18'h0;
  logic [15:0] pd = 16'h0;
  logic [15:0] held = 16'h0;
  logic hv_reset = 1'b0, lockout = 1'b0; // levels this bench cannot make

  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    ready_busy_out = 1'b1;
  end

  // command decoder, entered once per accepted write cycle
  task automatic take(input logic [17:0] a, input logic [15:0] d);
    logic [17:0] u1;
    logic [17:0] u2;
    logic [15:0] c;
    u1 = byte_n_in ? `FH_UNLOCK1_ADDR : `FH_UNLOCK1_ADDR << 1;
    u2 = byte_n_in ? `FH_UNLOCK2_ADDR : `FH_UNLOCK2_ADDR << 1;
    c = {8'h00, d[7:0]};
    if (st == 5) return;
    if (c == `FH_RESET_CMD) st = 0;
    else if (st == 1) st = (a == u2 && c == `FH_UNLOCK2_DATA) ? 2 : 0;
    else if (st == 2 && a == u1 && c == `FH_AUTOSEL_CMD) st = 4;
    else if (st == 2 && a == u1 && c == `FH_PROG_CMD) st = 3;
    else if (st == 3 && prot[a[17:15]] && !hv_reset) st = 0;
    else if (st == 3) begin
      pa = a;
      pd = byte_n_in ? d : {8'hff, d[7:0]};
      st = ((~mem[a[7:0]] & pd) != 16'h0) ? 6 : 5;
      ready_busy_out = (st != 5);
    end else if (st != 4 && st != 6) st = (a == u1 && c == `FH_UNLOCK1_DATA) ? 1 : 0;
  endtask

  // address on the later falling strobe, data on the earlier rising one
  always @(negedge we_n_in) if (!ce_n_in) la = addr_in;
  always @(posedge we_n_in)
    if (!ce_n_in && oe_n_in && reset_n_in && !lockout) take(la, dq_in);

  // embedded program; limitation: a restart within PROG_NS of an abort may finish early
  always begin
    wait (st == 5);
    #(PROG_NS);
    if (st == 5) begin
      mem[pa[7:0]] = mem[pa[7:0]] & pd;
      st = 0;
      ready_busy_out = 1'b1;
    end
  end

  // hardware reset aborts at once, busy held until the internal reset is over
  always @(negedge reset_n_in) begin
    st = 0;
    ready_busy_out = 1'b0;
    #(RDY_NS);
    ready_busy_out = 1'b1;
  end

  function automatic logic [15:0] rd_val(input logic [17:0] a);
    logic [7:0] idx;
    idx = byte_n_in ? a[7:0] : {1'b0, a[7:1]};
    if (st == 5 || st == 6) return {8'h00, ~pd[7], 1'b0, st == 6, 5'h00};
    if (st != 4) return mem[a[7:0]];
    if (idx == 8'h00) return MAKER_CODE;
    if (idx == 8'h01) return DEVICE_CODE;
    if (idx == 8'h02) return {15'h0, prot[a[17:15]]};
    return 16'h0000;
  endfunction

  // a released bus shows the inverse of its last value so a stale sample stands out
  always @(posedge oe_n_in) held = rd_val(addr_in);
  always_comb dq_out = (!ce_n_in && !oe_n_in) ? rd_val(addr_in) : ~held;
endmodule // flash_dev_model

// File: testbench/testbench.sv
// self-checking bench: host controller over avalon-mm against the behavioural flash
// assumes flash_dev_model and the design's consts header and package are compiled alongside
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module testbench;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [17:0] fl_addr;
  logic [15:0] fl_dq_host, fl_dq_dev, fl_dq;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_byte_n, fl_reset_n, fl_ready;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [17:0] sel_addr [6] = '{18'h0, 18'h1, 18'h08002, 18'h0, 18'h2, 18'h08004};
  logic [15:0] sel_exp [3] = '{16'h005a, 16'h00c3, 16'h0000};

  always #2.5 mclk_in = ~mclk_in;
  // shared data wire: the host drives it only while its enable is high
  assign fl_dq = fl_dq_oe ? fl_dq_host : fl_dq_dev;

  flash_host #(.POLL_LIMIT(16'h0010)) DUT (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .flash_addr_out(fl_addr), .flash_dq_in(fl_dq), .flash_dq_out(fl_dq_host),
    .flash_dq_oe_out(fl_dq_oe), .flash_ce_n_out(fl_ce_n), .flash_we_n_out(fl_we_n),
    .flash_oe_n_out(fl_oe_n), .flash_byte_n_out(fl_byte_n), .flash_reset_n_out(fl_reset_n),
    .ready_busy_in(fl_ready));
  flash_dev_model MODEL (
    .addr_in(fl_addr), .dq_in(fl_dq), .ce_n_in(fl_ce_n), .we_n_in(fl_we_n), .oe_n_in(fl_oe_n),
    .byte_n_in(fl_byte_n), .reset_n_in(fl_reset_n), .dq_out(fl_dq_dev), .ready_busy_out(fl_ready));

  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // avalon master: request held until waitrequest is sampled low
  task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk_in); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk_in); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] d;
    av_rd(a, d);
    chk(what, exp, d);
  endtask

  // start an operation and poll busy; the poll count bounds a stuck controller
  task automatic run_op(input flash_host_pkg::op_t o, input logic bm);
    logic [31:0] s;
    int n;
    av_wr(`FH_REG_CTRL, {27'h0, bm, 1'b0, o});
    n = 0;
    do begin
      av_rd(`FH_REG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 999);
    chk("busy", 32'h0, {31'h0, s[0]});
  endtask

  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge mclk_in); // let the ready synchroniser fill
    rd_chk("status", `FH_REG_STATUS, 32'h0000_0002);
    av_wr(3'h6, 32'hffff_ffff);
    rd_chk("unmapped", 3'h6, 32'h0);
    // word program of a fresh cell, then read back through the array
    av_wr(`FH_REG_ADDR, 32'h10);
    av_wr(`FH_REG_DATA, 32'h1234);
    run_op(flash_host_pkg::OP_PROGRAM, 1'b0);
    rd_chk("status", `FH_REG_STATUS, 32'h1234_0002);
    chk("cell", 32'h1234, {16'h0, MODEL.mem[8'h10]});
    run_op(flash_host_pkg::OP_READ, 1'b0);
    rd_chk("rdata", `FH_REG_RDATA, 32'h1234);
    // raising a zero bit fails; the host must leave the fault with a reset command
    av_wr(`FH_REG_DATA, 32'h1235);
    run_op(flash_host_pkg::OP_PROGRAM, 1'b0);
    av_rd(`FH_REG_STATUS, rv);
    chk("flags", 32'h14, rv & 32'h1c);
    chk("state", 32'h0, MODEL.st);
    run_op(flash_host_pkg::OP_READ, 1'b0);
    rd_chk("rdata", `FH_REG_RDATA, 32'h1234);
    // identification in both widths, many reads from one entry
    run_op(flash_host_pkg::OP_AUTOSEL, 1'b0);
    av_rd(`FH_REG_STATUS, rv);
    chk("autosel", 32'h8, rv & 32'h8);
    for (int i = 0; i < 6; i++) begin
      av_wr(`FH_REG_ADDR, {14'h0, sel_addr[i]});
      run_op(flash_host_pkg::OP_READ, i > 2);
      rd_chk("id", `FH_REG_RDATA, {16'h0, sel_exp[i % 3]});
    end
    run_op(flash_host_pkg::OP_RESET, 1'b0);
    av_rd(`FH_REG_STATUS, rv);
    chk("autosel", 32'h0, rv & 32'h8);
    av_wr(`FH_REG_ADDR, 32'h10);
    run_op(flash_host_pkg::OP_READ, 1'b0);
    rd_chk("rdata", `FH_REG_RDATA, 32'h1234);
    // byte-wide program needs the doubled unlock addresses
    av_wr(`FH_REG_ADDR, 32'h20);
    av_wr(`FH_REG_DATA, 32'ha5);
    run_op(flash_host_pkg::OP_PROGRAM, 1'b1);
    chk("cell", 32'ha5, {24'h0, MODEL.mem[8'h20][7:0]});
    run_op(flash_host_pkg::OP_HWRESET, 1'b0);
    av_rd(`FH_REG_STATUS, rv);
    chk("ready", 32'h2, rv & 32'h3);
    tally_and_finish();
  end
endmodule // testbench
